// >>> verilog/spc_pkg.sv
// constants for the serial port configuration register group
package spc_pkg;
   localparam logic [11:0] SPC_SETUP_OFS = 12'h000;
   localparam logic [11:0] SPC_VARIANT_OFS = 12'h003;
   localparam logic [11:0] SPC_BANK_OFS = 12'h004;
   localparam logic [11:0] SPC_TAG_LO_OFS = 12'h005;
   localparam logic [11:0] SPC_TAG_HI_OFS = 12'h006;
   localparam int SPC_SPLIT_BIT = 7;
   localparam int SPC_LSB_BIT = 6;
   localparam int SPC_SRST_BIT = 5;
   localparam int SPC_BANK_BIT = 0;
   localparam logic SPC_SPLIT_RST = 1'b0;
   localparam logic SPC_LSB_RST = 1'b0;
   localparam logic SPC_BANK_RST = 1'b0;
   localparam logic [15:0] SPC_TAG_RST = 16'h0000;
   // arbitrary value, not tied to any real part
   localparam logic [7:0] SPC_VARIANT_DEF = 8'h5a;
endpackage

// >>> verilog/spc_pin_steer.sv
// data pin steering for three-wire and four-wire operation
`timescale 1ns/1ps
module spc_pin_steer
   import spc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic split,
   input wire logic read_bit,
   input wire logic read_drive,
   input wire logic data_pin_i,
   output logic data_pin_o,
   output logic data_pin_oe,
   output logic serial_output_pin_o,
   output logic serial_output_pin_oe,
   output logic data_in_sync
);
   logic meta_q, meta_d, sync_q, sync_d;

   always_comb begin
      meta_d = data_pin_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign data_in_sync = sync_q;
   assign data_pin_o = read_bit;
   assign data_pin_oe = read_drive && !split;
   assign serial_output_pin_o = read_bit;
   assign serial_output_pin_oe = read_drive && split;
endmodule

// >>> verilog/spc_config_regs.sv
// serial port configuration register group with buffer and active banks
//
// Summary of operation
// - split bit clear: data pin carries writes and reads, output pin floats.
// - split bit set: reads leave only on the separate output pin.
// - order bit clear: msb first, address decrements per byte.
// - order bit set: lsb first, address increments per byte.
// - in i2c mode the order bit is ignored and bits 7:6 read zero and take no writes; a held split bit still steers reads.
// - soft reset with load pin high reloads all from nonvolatile memory.
// - soft reset with load pin low restores defaults; bit self-clears.
// - eight-bit read-only variant identifier; writes do nothing.
// - bank select clear: reads return buffer registers.
// - bank select set: reads return active registers.
// - sixteen-bit version tag, low byte first, high byte next.
// - version tag resets to zero, saved in memory, affects nothing.
`timescale 1ns/1ps
module spc_config_regs
   import spc_pkg::*;
#(
   parameter logic [7:0] VARIANT_ID = SPC_VARIANT_DEF
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic i2c_mode,
   input wire logic nvm_load_pin,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic io_update,
   input wire logic [7:0] nvm_setup,
   input wire logic [7:0] nvm_bank,
   input wire logic [15:0] nvm_tag,
   input wire logic read_bit,
   input wire logic read_drive,
   input wire logic data_pin_i,
   output logic [7:0] reg_rdata,
   output logic shift_lsb_first,
   output logic addr_step_up,
   output logic output_pin_split,
   output logic [15:0] user_version_tag,
   output logic nvm_reload,
   output logic data_pin_o,
   output logic data_pin_oe,
   output logic serial_output_pin_o,
   output logic serial_output_pin_oe,
   output logic data_in_sync
);
   logic split_q, split_d, lsb_q, lsb_d, bank_q, bank_d, srst_q, srst_d;
   logic [15:0] tag_buf_q, tag_buf_d, tag_act_q, tag_act_d;
   logic [7:0] rdata_q, rdata_d;
   logic pin_meta_q, pin_meta_d, pin_sync_q, pin_sync_d;
   logic [7:0] setup_view;

   // low nibble reads as the mirror of the high nibble
   function automatic logic [7:0] mirror_byte(input logic [3:0] hi);
      mirror_byte = {hi, hi[0], hi[1], hi[2], hi[3]};
   endfunction

   // both upper bits read as zero in i2c mode
   assign setup_view = mirror_byte({split_q & !i2c_mode, lsb_q & !i2c_mode, srst_q, 1'b0});

   always_comb begin
      pin_meta_d = nvm_load_pin;
      pin_sync_d = pin_meta_q;
   end

   always_comb begin
      split_d = split_q;
      lsb_d = lsb_q;
      bank_d = bank_q;
      srst_d = 1'b0;
      tag_buf_d = tag_buf_q;
      tag_act_d = tag_act_q;
      if (srst_q) begin
         if (pin_sync_q) begin
            split_d = nvm_setup[SPC_SPLIT_BIT];
            lsb_d = nvm_setup[SPC_LSB_BIT];
            bank_d = nvm_bank[SPC_BANK_BIT];
            tag_buf_d = nvm_tag;
            tag_act_d = nvm_tag;
         end else begin
            split_d = SPC_SPLIT_RST;
            lsb_d = SPC_LSB_RST;
            bank_d = SPC_BANK_RST;
            tag_buf_d = SPC_TAG_RST;
            tag_act_d = SPC_TAG_RST;
         end
      end else begin
         if (io_update) begin
            tag_act_d = tag_buf_q;
         end
         if (reg_wr) begin
            case (reg_addr)
               SPC_SETUP_OFS: begin
                  split_d = i2c_mode ? split_q : reg_wdata[SPC_SPLIT_BIT];
                  lsb_d = i2c_mode ? lsb_q : reg_wdata[SPC_LSB_BIT];
                  srst_d = reg_wdata[SPC_SRST_BIT];
               end
               SPC_BANK_OFS: bank_d = reg_wdata[SPC_BANK_BIT];
               SPC_TAG_LO_OFS: tag_buf_d[7:0] = reg_wdata;
               SPC_TAG_HI_OFS: tag_buf_d[15:8] = reg_wdata;
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd) begin
         case (reg_addr)
            SPC_SETUP_OFS: rdata_d = setup_view;
            SPC_VARIANT_OFS: rdata_d = VARIANT_ID;
            SPC_BANK_OFS: rdata_d = {7'h00, bank_q};
            SPC_TAG_LO_OFS: rdata_d = bank_q ? tag_act_q[7:0] : tag_buf_q[7:0];
            SPC_TAG_HI_OFS: rdata_d = bank_q ? tag_act_q[15:8] : tag_buf_q[15:8];
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         split_q <= SPC_SPLIT_RST;
         lsb_q <= SPC_LSB_RST;
         bank_q <= SPC_BANK_RST;
         srst_q <= 1'b0;
         tag_buf_q <= SPC_TAG_RST;
         tag_act_q <= SPC_TAG_RST;
         rdata_q <= 8'h00;
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end else begin
         split_q <= split_d;
         lsb_q <= lsb_d;
         bank_q <= bank_d;
         srst_q <= srst_d;
         tag_buf_q <= tag_buf_d;
         tag_act_q <= tag_act_d;
         rdata_q <= rdata_d;
         pin_meta_q <= pin_meta_d;
         pin_sync_q <= pin_sync_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign shift_lsb_first = lsb_q && !i2c_mode;
   assign addr_step_up = lsb_q && !i2c_mode;
   assign output_pin_split = split_q;
   assign user_version_tag = tag_act_q;
   assign nvm_reload = srst_q && pin_sync_q;

   spc_pin_steer u_steer (
      .clk(clk),
      .rst(rst),
      .split(split_q),
      .read_bit(read_bit),
      .read_drive(read_drive),
      .data_pin_i(data_pin_i),
      .data_pin_o(data_pin_o),
      .data_pin_oe(data_pin_oe),
      .serial_output_pin_o(serial_output_pin_o),
      .serial_output_pin_oe(serial_output_pin_oe),
      .data_in_sync(data_in_sync)
   );

   // pin steering
   float_pin_a: assert property (@(posedge clk) disable iff (rst)
      !output_pin_split |-> !serial_output_pin_oe)
      else $error("output pin driven while not split");
   split_read_a: assert property (@(posedge clk) disable iff (rst)
      output_pin_split && read_drive |-> serial_output_pin_oe && !data_pin_oe)
      else $error("split read on wrong pin");

   // bit order and i2c masking
   order_msb_a: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == SPC_SETUP_OFS && !reg_wdata[6] && !i2c_mode && !srst_q
      |=> !shift_lsb_first && !addr_step_up)
      else $error("msb order not taken");
   order_lsb_a: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == SPC_SETUP_OFS && reg_wdata[SPC_LSB_BIT] && !i2c_mode && !srst_q
      ##1 !i2c_mode |-> shift_lsb_first && addr_step_up)
      else $error("lsb order not taken");
   i2c_ignore_a: assert property (@(posedge clk) disable iff (rst)
      i2c_mode |-> !shift_lsb_first)
      else $error("order bit used in i2c mode");
   i2c_split_a: assert property (@(posedge clk) disable iff (rst)
      i2c_mode && reg_wr && reg_addr == SPC_SETUP_OFS && !srst_q
      |=> output_pin_split == $past(output_pin_split))
      else $error("split bit written in i2c mode");

   // soft reset
   reload_nvm_a: assert property (@(posedge clk) disable iff (rst)
      srst_q && pin_sync_q |=> user_version_tag == $past(nvm_tag) && !srst_q)
      else $error("nonvolatile reload wrong");
   reload_def_a: assert property (@(posedge clk) disable iff (rst)
      srst_q && !pin_sync_q |=> user_version_tag == SPC_TAG_RST && !output_pin_split)
      else $error("default reload wrong");
   srst_clear_a: assert property (@(posedge clk) disable iff (rst)
      srst_q |=> !srst_q)
      else $error("soft reset did not clear");

   // readback and version tag
   variant_ro_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == SPC_VARIANT_OFS |=> reg_rdata == VARIANT_ID)
      else $error("variant id read wrong");
   bank_write_a: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == SPC_BANK_OFS && !srst_q |=> bank_q == $past(reg_wdata[0]))
      else $error("bank select not written");
   bank_buf_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == SPC_TAG_LO_OFS && !bank_q |=> reg_rdata == $past(tag_buf_q[7:0]))
      else $error("buffer readback wrong");
   bank_act_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == SPC_TAG_HI_OFS && bank_q |=> reg_rdata == $past(tag_act_q[15:8]))
      else $error("active readback wrong");
   tag_write_a: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == SPC_TAG_HI_OFS && !srst_q |=> tag_buf_q[15:8] == $past(reg_wdata))
      else $error("tag high byte not written");
   tag_hold_a: assert property (@(posedge clk) disable iff (rst)
      !io_update && !srst_q |=> tag_act_q == $past(tag_act_q))
      else $error("active tag changed without update");

   // unused bits
   unused_zero_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == SPC_BANK_OFS |=> reg_rdata[7:1] == 7'h00)
      else $error("unused bits not zero");
   setup_gap_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == SPC_SETUP_OFS |=> reg_rdata[4:3] == 2'b00)
      else $error("setup unused bits not zero");
endmodule

// >>> dv/spc_host_model.sv
// host side of the shared data pin
`timescale 1ns/1ps
module spc_host_model (
   input wire logic clk,
   input wire logic dev_o,
   input wire logic dev_oe,
   input wire logic host_oe,
   input wire logic host_bit,
   output logic pin_level
);
   logic last_q = 1'b0;
   // remember the last level that someone actually drove
   always_ff @(posedge clk) begin
      if (dev_oe || host_oe) begin
         last_q <= pin_level;
      end
   end
   // a released line shows the inverse of its last level
   always_comb begin
      if (dev_oe) begin
         pin_level = dev_o;
      end else if (host_oe) begin
         pin_level = host_bit;
      end else begin
         pin_level = ~last_q;
      end
   end
endmodule

// >>> dv/spc_config_regs_bench.sv
// self-checking bench for the configuration register group
`timescale 1ns/1ps
module spc_config_regs_bench;
   import spc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, i2c_mode = 1'b0, nvm_load_pin = 1'b0, io_update = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, read_bit = 1'b0, read_drive = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00, nvm_setup = 8'h81, nvm_bank = 8'h01, reg_rdata;
   logic [15:0] nvm_tag = 16'hbeef, user_version_tag;
   logic shift_lsb_first, addr_step_up, output_pin_split, nvm_reload, data_pin_i;
   logic data_pin_o, data_pin_oe, serial_output_pin_o, serial_output_pin_oe, data_in_sync;
   int n_errors = 0, checks = 0, cycles = 0, reloads = 0;
   always #4 clk = ~clk;
   spc_config_regs u_spc_config_regs (.clk, .rst, .i2c_mode, .nvm_load_pin, .reg_wr,
      .reg_rd, .reg_addr, .reg_wdata, .io_update, .nvm_setup, .nvm_bank, .nvm_tag,
      .read_bit, .read_drive, .data_pin_i, .reg_rdata, .shift_lsb_first, .addr_step_up,
      .output_pin_split, .user_version_tag, .nvm_reload, .data_pin_o, .data_pin_oe,
      .serial_output_pin_o, .serial_output_pin_oe, .data_in_sync);
   spc_host_model u_spc_host_model (.clk, .dev_o(data_pin_o), .dev_oe(data_pin_oe),
      .host_oe(reg_wr), .host_bit(reg_wdata[7]), .pin_level(data_pin_i));
   task automatic conclude();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (nvm_reload === 1'b1) begin
         reloads++;
      end
      if (cycles == 2000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk_byte(reg_rdata, exp);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(SPC_SETUP_OFS, 8'h00);
      rd(SPC_BANK_OFS, 8'h00);
      rd(SPC_TAG_HI_OFS, 8'h00);
      rd(12'h001, 8'h00);
      wr(SPC_VARIANT_OFS, 8'hff);
      rd(SPC_VARIANT_OFS, SPC_VARIANT_DEF);
      @(posedge clk) read_drive <= 1'b1;
      @(posedge clk) read_bit <= 1'b1;
      #1 chk_sig({data_pin_oe, data_pin_o, serial_output_pin_oe, data_pin_i}, 4'b1101);
      repeat (2) @(posedge clk);
      #1 chk_sig(data_in_sync, 1'b1);
      wr(SPC_SETUP_OFS, 8'h81);
      chk_sig({data_pin_oe, serial_output_pin_oe, serial_output_pin_o}, 3'b011);
      rd(SPC_SETUP_OFS, 8'h81);
      wr(SPC_SETUP_OFS, 8'h42);
      chk_sig({shift_lsb_first, addr_step_up, output_pin_split}, 3'b110);
      wr(SPC_SETUP_OFS, 8'h00);
      chk_sig({shift_lsb_first, addr_step_up}, 2'b00);
      @(posedge clk) i2c_mode <= 1'b1;
      wr(SPC_SETUP_OFS, 8'hc3);
      chk_sig(shift_lsb_first, 1'b0);
      rd(SPC_SETUP_OFS, 8'h00);
      @(posedge clk) i2c_mode <= 1'b0;
      #1 chk_sig({shift_lsb_first, output_pin_split}, 2'b00);
      wr(SPC_TAG_LO_OFS, 8'h34);
      wr(SPC_TAG_HI_OFS, 8'h12);
      rd(SPC_TAG_LO_OFS, 8'h34);
      chk_sig(user_version_tag, 16'h0000);
      wr(SPC_BANK_OFS, 8'hff);
      rd(SPC_BANK_OFS, 8'h01);
      rd(SPC_TAG_HI_OFS, 8'h00);
      @(posedge clk) io_update <= 1'b1;
      @(posedge clk) io_update <= 1'b0;
      #1 chk_sig(user_version_tag, 16'h1234);
      rd(SPC_TAG_HI_OFS, 8'h12);
      wr(SPC_SETUP_OFS, 8'h24);
      repeat (2) @(posedge clk);
      rd(SPC_SETUP_OFS, 8'h00);
      rd(SPC_BANK_OFS, 8'h00);
      rd(SPC_TAG_LO_OFS, 8'h00);
      chk_sig(user_version_tag, 16'h0000);
      chk_sig(16'(reloads), 16'h0000);
      @(posedge clk) nvm_load_pin <= 1'b1;
      repeat (3) @(posedge clk);
      wr(SPC_SETUP_OFS, 8'h24);
      repeat (2) @(posedge clk);
      chk_sig(16'(reloads), 16'h0001);
      chk_sig(user_version_tag, 16'hbeef);
      rd(SPC_SETUP_OFS, 8'h81);
      rd(SPC_TAG_HI_OFS, 8'hbe);
      conclude();
   end
endmodule
